// file: core/lcdc_top.sv
// Segment LCD controller core: APB registers, display RAM and scan-out.
// Assumes an APB master on clk and a standby level from power control.
`timescale 1ns/1ps
module lcdc_top
  import lcdc_pkg::*;
#(
  parameter int SEG_PINS = 40,
  parameter int RAM_BYTES = 64
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock and power inputs
  input wire logic subClkPin,
  input wire logic standbyIn,
  // Panel drive
  output logic dividerOn,
  output logic [3:0] backplane,
  output logic acPhase,
  output logic [SEG_PINS-1:0] segData,
  output logic [SEG_PINS-1:0] segActive,
  // Expander pins
  output logic extData,
  output logic extShift,
  output logic extLatch,
  output logic extOeN
);
  localparam logic [3:0] TOP_GRP = 4'(SEG_PINS / 4 - 1);

  logic [6:0] ctrl_ff, nxt_ctrl; // Writable control bits
  logic [7:0] mode_ff, nxt_mode; // Duty, doubling, expansion, span
  logic [7:0] ram_ff [RAM_BYTES]; // Display RAM
  logic [7:0] nxt_ram [RAM_BYTES];
  logic [31:0] rd_ff, nxt_rd;
  logic rdy_ff, nxt_rdy;
  logic err_ff, nxt_err;
  logic div_ff, nxt_div;
  logic [3:0] bp_ff, nxt_bp;
  logic ac_ff, nxt_ac;
  logic [SEG_PINS-1:0] seg_ff, nxt_seg;
  logic [SEG_PINS-1:0] act_ff, nxt_act;
  logic [EXT_SEGS-1:0] extBits;
  logic wrEn, running, showRam, extMode;
  logic [3:0] span;
  lcdc_duty_t dutySet;

  lcdc_tick_if tk ();

  // Address decode shared by the error answer and the write strobe
  function automatic logic apbHit(input logic [7:0] a);
    return (a == OFF_CTRL) || (a == OFF_MODE) || (a == OFF_STAT) ||
      (a[7:6] == OFF_RAM[7:6]);
  endfunction

  // One display RAM bit; the fast frame sees only the upper half
  function automatic logic ramBit(input logic [5:0] off, input logic hi,
    input logic [1:0] com, input logic fast);
    logic [5:0] idx;
    idx = fast ? {1'b1, off[4:0]} : off;
    return ram_ff[idx][{hi, com}];
  endfunction

  // Number of segment groups minus one
  function automatic logic [3:0] spanEff(input logic [3:0] c);
    return c[3] ? {3'h4, c[0]} : {1'b0, c[2:0]};
  endfunction

  assign dutySet = lcdc_duty_t'(mode_ff[1:0]);
  assign span = mode_ff[MODE_SPAN +: 4];
  assign extMode = mode_ff[MODE_EXP];
  // standby halts like a cleared run bit
  assign running = ctrl_ff[CTRL_RUN] && !standbyIn;
  assign showRam = ctrl_ff[CTRL_SHOW];
  assign wrEn = psel && penable && rdy_ff && pwrite && !err_ff;

  lcdc_frame_gen u_frame (
    .clk(clk),
    .rstn(rstn),
    .subClkPin(subClkPin),
    .frameSel(ctrl_ff[3:0]),
    .duty(dutySet),
    .run(running),
    .tk(tk.gen)
  );

  lcdc_expander u_exp (
    .clk(clk),
    .rstn(rstn),
    .standbyIn(standbyIn),
    .run(running),
    .tk(tk.exp),
    .extData(extData),
    .extShift(extShift),
    .extLatch(extLatch),
    .extOeN(extOeN)
  );

  // APB answer in the first access cycle, no wait states
  always_comb
  begin
    nxt_rdy = psel && !penable;
    nxt_err = psel && !penable && !apbHit(paddr);
    nxt_rd = 32'h0000_0000;
    if (psel && !penable && !pwrite)
    begin
      if (paddr == OFF_CTRL)
      begin
        nxt_rd = {24'h000000, 1'b1, ctrl_ff};
      end
      else if (paddr == OFF_MODE)
      begin
        nxt_rd = {24'h000000, mode_ff};
      end
      else if (paddr == OFF_STAT)
      begin
        nxt_rd = {27'h0000000, running, tk.comIdx, ac_ff, div_ff};
      end
      else if (paddr[7:6] == OFF_RAM[7:6])
      begin
        nxt_rd = {ram_ff[{paddr[5:2], 2'h3}], ram_ff[{paddr[5:2], 2'h2}],
          ram_ff[{paddr[5:2], 2'h1}], ram_ff[{paddr[5:2], 2'h0}]};
      end
    end
  end

  // Register and RAM writes; a halt leaves them untouched
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_mode = mode_ff;
    nxt_ram = ram_ff;
    if (wrEn && paddr == OFF_CTRL && pstrb[0])
    begin
      nxt_ctrl = pwdata[6:0];
    end
    if (wrEn && paddr == OFF_MODE && pstrb[0])
    begin
      nxt_mode = pwdata[7:0];
    end
    // byte lanes allow byte or word
    for (int b = 0; b < 4; b++)
    begin
      if (wrEn && paddr[7:6] == OFF_RAM[7:6] && pstrb[b])
      begin
        nxt_ram[{paddr[5:2], 2'(b)}] = pwdata[8*b +: 8];
      end
    end
  end

  // Panel drive levels
  always_comb
  begin
    nxt_div = ctrl_ff[CTRL_DIVIDER] && running;
    nxt_ac = (running && tk.frameEnd) ? !ac_ff : ac_ff;
    nxt_bp = 4'h0;
    if (running)
    begin
      unique case (tk.duty)
        DUTY_STATIC: nxt_bp = mode_ff[MODE_DBL] ? 4'hf : 4'h1;
        DUTY_HALF:
          if (mode_ff[MODE_DBL])
          begin
            nxt_bp = tk.comIdx[0] ? 4'hc : 4'h3;
          end
          else
          begin
            nxt_bp = tk.comIdx[0] ? 4'h2 : 4'h1;
          end
        DUTY_THIRD, DUTY_QUARTER: nxt_bp = 4'(4'h1 << tk.comIdx);
      endcase
    end
  end

  // On-chip segment data, rebuilt every cycle from RAM
  always_comb
  begin
    logic [3:0] grp;
    grp = 4'h0;
    nxt_seg = '0;
    nxt_act = '0;
    for (int s = 0; s < SEG_PINS; s++)
    begin
      grp = 4'(s / 4);
      // span picks segments from the top
      nxt_act[s] = (grp >= TOP_GRP - spanEff(span)) && !(extMode && grp == TOP_GRP);
      nxt_seg[s] = running && showRam && nxt_act[s] &&
        ramBit(6'(s / 2), 1'(s % 2), tk.comIdx, tk.fast);
    end
  end

  // Expander data for the current backplane
  always_comb
  begin
    logic [5:0] base;
    base = (span == 4'h0) ? 6'h00 : EXT_BYTE_OFF;
    extBits = '0;
    for (int j = 0; j < EXT_SEGS; j++)
    begin
      extBits[j] = showRam && ramBit(6'(base + 6'(j / 2)), 1'(j % 2), tk.comIdx, tk.fast);
    end
  end

  assign tk.extOn = extMode;
  assign tk.extBits = extBits;

  // State registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl_ff <= CTRL_RESET[6:0];
      mode_ff <= MODE_RESET;
      ram_ff <= '{default: 8'h00};
      rd_ff <= 32'h0000_0000;
      rdy_ff <= 1'b0;
      err_ff <= 1'b0;
      div_ff <= 1'b0;
      bp_ff <= 4'h0;
      ac_ff <= 1'b0;
      seg_ff <= '0;
      act_ff <= '0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      mode_ff <= nxt_mode;
      ram_ff <= nxt_ram;
      rd_ff <= nxt_rd;
      rdy_ff <= nxt_rdy;
      err_ff <= nxt_err;
      div_ff <= nxt_div;
      bp_ff <= nxt_bp;
      ac_ff <= nxt_ac;
      seg_ff <= nxt_seg;
      act_ff <= nxt_act;
    end
  end

  assign prdata = rd_ff;
  assign pready = rdy_ff;
  assign pslverr = err_ff;
  assign dividerOn = div_ff;
  assign backplane = bp_ff;
  assign acPhase = ac_ff;
  assign segData = seg_ff;
  assign segActive = act_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_ctrlRead;
    psel && !penable && !pwrite && paddr == OFF_CTRL;
  endsequence
  sequence s_ctrlWrite;
    psel && penable && rdy_ff && pwrite && paddr == OFF_CTRL && pstrb[0];
  endsequence

  a_reset_value: assert property (
    $rose(rstn) |-> {1'b1, ctrl_ff} == CTRL_RESET) else $error("control reset value wrong");
  a_top_bit_one: assert property (
    s_ctrlRead |=> prdata[7] && pready) else $error("control top bit not one");
  a_write_back: assert property (
    s_ctrlWrite |=> ctrl_ff == $past(pwdata[6:0])) else $error("control write lost");
  a_div_follow: assert property (
    ctrl_ff[CTRL_DIVIDER] && running |=> dividerOn) else $error("divider not on");
  a_div_forced: assert property (
    !ctrl_ff[CTRL_RUN] || standbyIn |=> !dividerOn) else $error("divider not forced off");
  a_halt_hold: assert property (
    !running && !psel |=> $stable(mode_ff) && $stable(ctrl_ff) && $stable(acPhase))
    else $error("halt changed state");
  a_blank_out: assert property (
    !showRam |=> segData == '0) else $error("blank data not blank");
  a_dbl_static: assert property (
    running && tk.duty == DUTY_STATIC && mode_ff[MODE_DBL] |=> backplane == 4'hf)
    else $error("static doubling wrong");
  a_dbl_half: assert property (
    running && tk.duty == DUTY_HALF && mode_ff[MODE_DBL] |=>
    backplane[0] == backplane[1] && backplane[2] == backplane[3] && backplane != 4'h0)
    else $error("half duty doubling wrong");
  a_exp_pins: assert property (
    extMode |=> segActive[SEG_PINS-1 -: 4] == 4'h0) else $error("expansion pins still segments");
  a_standby_float: assert property (
    standbyIn |=> extOeN) else $error("expansion pins driven in standby");
endmodule

// file: core/lcdc_pkg.sv
// Constants, field positions and types for the segment LCD control block.
// Assumes a single 10 MHz system clock and APB register access.
package lcdc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_RAM = 8'h40;
  // Values after reset
  localparam logic [7:0] CTRL_RESET = 8'h80;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // Control register field positions
  localparam int CTRL_DIVIDER = 6;
  localparam int CTRL_RUN = 5;
  localparam int CTRL_SHOW = 4;
  // Mode register field positions
  localparam int MODE_DBL = 2;
  localparam int MODE_EXP = 3;
  localparam int MODE_SPAN = 4;
  // Source ticks per backplane slot at the slow subclock rate
  localparam logic [9:0] SLOT_STATIC = 10'h200;
  localparam logic [9:0] SLOT_HALF = 10'h100;
  localparam logic [9:0] SLOT_MULTI = 10'h080;
  // External segment count and its RAM byte start
  localparam int EXT_SEGS = 80;
  localparam logic [5:0] EXT_BYTE_OFF = 6'h14;
  // Expander shift phases: two clock cycles per bit
  localparam logic [7:0] EXT_PHASES = 8'ha0;
  // Duty choices, code equals backplane count minus one
  typedef enum logic [1:0] {DUTY_STATIC, DUTY_HALF, DUTY_THIRD, DUTY_QUARTER} lcdc_duty_t;
endpackage

// file: core/lcdc_tick_if.sv
// Carrier between the frame timer, the core and the expander serializer.
// Assumes all three sit on the same system clock.
`timescale 1ns/1ps
interface lcdc_tick_if;
  import lcdc_pkg::*;
  logic slotEnd; // One-cycle pulse at the end of a backplane slot
  logic frameEnd; // One-cycle pulse at the end of a frame
  logic [1:0] comIdx; // Active backplane index
  lcdc_duty_t duty; // Duty in force this frame
  logic fast; // Fastest subclock frame in force
  logic extOn; // Expansion pins in use
  logic [EXT_SEGS-1:0] extBits; // Expander data for the current slot
  modport gen (output slotEnd, frameEnd, comIdx, duty, fast);
  modport core (input slotEnd, frameEnd, comIdx, duty, fast, output extOn, extBits);
  modport exp (input slotEnd, extOn, extBits);
endinterface

// file: core/lcdc_frame_gen.sv
// Frame timer: picks the frame clock source and divides it into slots.
// Assumes the subclock pin is asynchronous to clk and much slower.
`timescale 1ns/1ps
module lcdc_frame_gen
  import lcdc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Watch subclock pin
  input wire logic subClkPin,
  // Live settings from the core
  input wire logic [3:0] frameSel,
  input wire lcdc_duty_t duty,
  input wire logic run,
  // Timing towards the core
  lcdc_tick_if.gen tk
);
  logic [2:0] sync_ff, nxt_sync; // Subclock synchroniser
  logic stable_ff, nxt_stable; // Filtered subclock level
  logic half_ff, nxt_half; // Subclock divided by two
  logic [7:0] pre_ff, nxt_pre; // System clock prescaler
  logic [9:0] cnt_ff, nxt_cnt; // Ticks within slot
  logic [1:0] com_ff, nxt_com; // Current backplane
  logic [3:0] sel_ff, nxt_sel; // Frame source in force
  lcdc_duty_t duty_ff, nxt_duty; // Duty in force
  logic slot_ff, nxt_slot; // Slot end pulse
  logic frame_ff, nxt_frame; // Frame end pulse
  logic subEdge, sysTick, srcTick, fastNow;
  logic [7:0] mask;
  logic [9:0] len;

  // Ticks per slot; the fast setting halves every length
  function automatic logic [9:0] slotLen(input lcdc_duty_t d, input logic f);
    logic [9:0] l;
    unique case (d)
      DUTY_STATIC: l = SLOT_STATIC;
      DUTY_HALF: l = SLOT_HALF;
      DUTY_THIRD, DUTY_QUARTER: l = SLOT_MULTI;
    endcase
    return f ? (l >> 1) : l;
  endfunction

  // Source selection and slot counting
  always_comb
  begin
    // Only the second and third stages are compared
    nxt_sync = {sync_ff[1:0], subClkPin};
    nxt_stable = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : stable_ff;
    subEdge = (sync_ff[1] == sync_ff[2]) && sync_ff[2] && !stable_ff;
    nxt_half = subEdge ? !half_ff : half_ff;
    nxt_pre = pre_ff + 8'h01;
    mask = 8'((9'h002 << sel_ff[2:0]) - 9'h001);
    sysTick = &(pre_ff | ~mask);
    fastNow = !sel_ff[3] && !sel_ff[1] && !sel_ff[0];
    srcTick = sel_ff[3] ? sysTick : (sel_ff[1] ? (subEdge && half_ff) : subEdge);
    len = slotLen(duty_ff, fastNow);
    nxt_cnt = cnt_ff;
    nxt_com = com_ff;
    nxt_sel = sel_ff;
    nxt_duty = duty_ff;
    nxt_slot = 1'b0;
    nxt_frame = 1'b0;
    if (!run)
    begin
      // Halted: counters hold, settings follow software
      nxt_sel = frameSel;
      nxt_duty = duty;
    end
    else if (srcTick)
    begin
      if (cnt_ff == len - 10'h001)
      begin
        nxt_cnt = 10'h000;
        nxt_slot = 1'b1;
        if (com_ff == 2'(duty_ff))
        begin
          nxt_com = 2'h0;
          nxt_frame = 1'b1;
          nxt_sel = frameSel;
          nxt_duty = duty;
        end
        else
        begin
          nxt_com = com_ff + 2'h1;
        end
      end
      else
      begin
        nxt_cnt = cnt_ff + 10'h001;
      end
    end
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sync_ff <= 3'h0;
      stable_ff <= 1'b0;
      half_ff <= 1'b0;
      pre_ff <= 8'h00;
      cnt_ff <= 10'h000;
      com_ff <= 2'h0;
      sel_ff <= 4'h0;
      duty_ff <= DUTY_STATIC;
      slot_ff <= 1'b0;
      frame_ff <= 1'b0;
    end
    else
    begin
      sync_ff <= nxt_sync;
      stable_ff <= nxt_stable;
      half_ff <= nxt_half;
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
      com_ff <= nxt_com;
      sel_ff <= nxt_sel;
      duty_ff <= nxt_duty;
      slot_ff <= nxt_slot;
      frame_ff <= nxt_frame;
    end
  end

  assign tk.slotEnd = slot_ff;
  assign tk.frameEnd = frame_ff;
  assign tk.comIdx = com_ff;
  assign tk.duty = duty_ff;
  assign tk.fast = !sel_ff[3] && !sel_ff[1] && !sel_ff[0];
endmodule

// file: core/lcdc_expander.sv
// Serializer for the external segment expander chip.
// Assumes a slot lasts longer than one full shift of all external bits.
`timescale 1ns/1ps
module lcdc_expander
  import lcdc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Power state
  input wire logic standbyIn,
  input wire logic run,
  // Data from the core
  lcdc_tick_if.exp tk,
  // Expander pins
  output logic extData,
  output logic extShift,
  output logic extLatch,
  output logic extOeN
);
  logic [EXT_SEGS-1:0] sh_ff, nxt_sh; // Bits still to send
  logic [7:0] ph_ff, nxt_ph; // Remaining shift phases
  logic dat_ff, nxt_dat;
  logic clk_ff, nxt_clk;
  logic lat_ff, nxt_lat;
  logic oen_ff, nxt_oen;

  // Shift sequence: data, rising shift clock, next bit, latch at end
  always_comb
  begin
    nxt_sh = sh_ff;
    nxt_ph = ph_ff;
    nxt_dat = dat_ff;
    nxt_clk = 1'b0;
    nxt_lat = 1'b0;
    nxt_oen = standbyIn || !tk.extOn;
    if (!run)
    begin
      // Halted: data holds, clocks low
      nxt_ph = 8'h00;
    end
    else if (tk.slotEnd && tk.extOn)
    begin
      nxt_sh = tk.extBits;
      nxt_ph = EXT_PHASES;
    end
    else if (ph_ff != 8'h00)
    begin
      nxt_ph = ph_ff - 8'h01;
      if (ph_ff[0])
      begin
        nxt_clk = 1'b1;
        nxt_sh = sh_ff >> 1;
      end
      else
      begin
        nxt_dat = sh_ff[0];
      end
      nxt_lat = (ph_ff == 8'h01);
    end
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sh_ff <= '0;
      ph_ff <= 8'h00;
      dat_ff <= 1'b0;
      clk_ff <= 1'b0;
      lat_ff <= 1'b0;
      oen_ff <= 1'b1;
    end
    else
    begin
      sh_ff <= nxt_sh;
      ph_ff <= nxt_ph;
      dat_ff <= nxt_dat;
      clk_ff <= nxt_clk;
      lat_ff <= nxt_lat;
      oen_ff <= nxt_oen;
    end
  end

  assign extData = dat_ff;
  assign extShift = clk_ff;
  assign extLatch = lat_ff;
  assign extOeN = oen_ff;
endmodule

// file: tb/lcdc_panel_model.sv
// Panel and expander side model: frame length and shifts per latch.
// Assumes the controller pins and clk are fed straight in.
`timescale 1ns/1ps
module lcdc_panel_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Panel and expander pins
  input wire logic acPhase,
  input wire logic extShift,
  input wire logic extLatch,
  // What the far side saw
  output int frameLen,
  output int frameCnt,
  output int lastShifts
);
  int runCnt; // Cycles since the last frame end
  int shiftCnt; // Shifts since the last latch
  logic prevAc; // AC phase one cycle ago
  // The panel only sees phase flips, so frame length is flip to flip
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      runCnt <= 0;
      frameLen <= 0;
      frameCnt <= 0;
      shiftCnt <= 0;
      lastShifts <= 0;
      prevAc <= 1'b0;
    end
    else
    begin
      prevAc <= acPhase;
      runCnt <= (acPhase != prevAc) ? 1 : runCnt + 1;
      if (acPhase != prevAc)
      begin
        frameLen <= runCnt;
        frameCnt <= frameCnt + 1;
      end
      // Latch comes with the final shift, so count that one too
      shiftCnt <= extLatch ? 0 : shiftCnt + int'(extShift);
      if (extLatch)
      begin
        lastShifts <= shiftCnt + int'(extShift);
      end
    end
  end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the segment LCD control block over APB.
// Assumes the package, the design and the panel model compile first.
`timescale 1ns/1ps
module testbench;
  import lcdc_pkg::*;
  // Bench drive
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic subClkPin = 1'b0, standbyIn = 1'b0;
  logic [1:0] subDiv = 2'h0;
  // Design outputs
  logic [31:0] prdata;
  logic pready, pslverr, dividerOn, acPhase, extData, extShift, extLatch, extOeN;
  logic [3:0] backplane;
  logic [39:0] segData, segActive;
  // Model view and tallies
  int frameLen, frameCnt, lastShifts;
  int miscompares = 0;
  int checkCount = 0;
  always #50 clk = ~clk;
  // Subclock pin at eight system cycles, far faster than a watch crystal
  always @(posedge clk)
  begin
    subDiv <= subDiv + 2'h1;
    if (subDiv == 2'h3)
      subClkPin <= ~subClkPin;
  end
  lcdc_top DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .subClkPin(subClkPin), .standbyIn(standbyIn), .dividerOn(dividerOn),
    .backplane(backplane), .acPhase(acPhase), .segData(segData), .segActive(segActive),
    .extData(extData), .extShift(extShift), .extLatch(extLatch), .extOeN(extOeN));
  lcdc_panel_model panel (.clk(clk), .rstn(rstn), .acPhase(acPhase), .extShift(extShift),
    .extLatch(extLatch), .frameLen(frameLen), .frameCnt(frameCnt), .lastShifts(lastShifts));
  // Verdict and end of run
  task automatic wrapUp();
    $display("Checks %0d, mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds everything until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      miscompares++;
      wrapUp();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 4'hf, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    chk({8'h00, r}, {8'h00, exp});
  endtask
  // Bounded wait for the next frame end seen by the panel
  task automatic waitFrame();
    int n0;
    int k;
    n0 = frameCnt;
    k = 0;
    while (frameCnt == n0 && k < 20000)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 20000)
    begin
      miscompares++;
      wrapUp();
    end
  endtask
  // New settings land at a frame end, so measure the frame after it
  task automatic frameIs(input int exp);
    waitFrame();
    waitFrame();
    chk(40'(frameLen), 40'(exp));
  endtask
  task automatic tRegs();
    logic [31:0] r;
    logic e;
    rd(OFF_CTRL, 32'h80);
    chk(dividerOn, 1'b0);
    wr(OFF_CTRL, 32'h7f);
    rd(OFF_CTRL, 32'hff);
    repeat (2) @(posedge clk);
    chk(dividerOn, 1'b1);
    wr(OFF_CTRL, 32'h40);
    repeat (2) @(posedge clk);
    chk(dividerOn, 1'b0);
    rd(OFF_CTRL, 32'hc0);
    apb(1'b0, 8'h30, 32'h0, 4'h0, r, e);
    chk({7'h0, e, r}, 40'h1_0000_0000);
  endtask
  task automatic tFrames();
    int ticks[4];
    ticks = '{int'(SLOT_STATIC), 2 * SLOT_HALF, 3 * SLOT_MULTI, 4 * SLOT_MULTI};
    wr(OFF_MODE, 32'h00);
    wr(OFF_CTRL, 32'h28);
    frameIs(2 * ticks[0]);
    wr(OFF_CTRL, 32'h29);
    frameIs(4 * ticks[0]);
    wr(OFF_CTRL, 32'h28);
    for (int d = 1; d < 4; d++)
    begin
      wr(OFF_MODE, 32'(d));
      frameIs(2 * ticks[d]);
    end
    wr(OFF_MODE, 32'h00);
    wr(OFF_CTRL, 32'h20);
    frameIs(4 * ticks[0]);
    wr(OFF_CTRL, 32'h21);
    frameIs(8 * ticks[0]);
    wr(OFF_CTRL, 32'h26);
    frameIs(16 * ticks[0]);
  endtask
  task automatic countHigh(output int c);
    c = 0;
    repeat (1100)
    begin
      @(posedge clk);
      c += int'(extData === 1'b1);
    end
  endtask
  task automatic tDisplay();
    logic [31:0] r;
    logic e;
    int c;
    for (int w = 0; w < 16; w++)
      wr(8'(OFF_RAM + 4 * w), 32'hffffffff);
    apb(1'b1, OFF_RAM, 32'h0, 4'h1, r, e);
    rd(OFF_RAM, 32'hffffff00);
    wr(OFF_RAM, 32'hffffffff);
    wr(OFF_MODE, 32'hf4);
    wr(OFF_CTRL, 32'h68);
    waitFrame();
    chk(segActive, {40{1'b1}});
    chk(segData, 40'h0);
    chk(backplane, 4'hf);
    wr(OFF_CTRL, 32'h78);
    waitFrame();
    chk(segData, {40{1'b1}});
    wr(OFF_MODE, 32'hf5);
    waitFrame();
    chk(backplane === 4'h3 || backplane === 4'hc, 1'b1);
    wr(OFF_MODE, 32'h00);
    waitFrame();
    chk(segActive, 40'hf0_0000_0000);
    // External-only mode: span zero with expansion on
    wr(OFF_MODE, 32'h08);
    waitFrame();
    waitFrame();
    chk(segActive, 40'h0);
    chk(extOeN, 1'b0);
    chk(40'(lastShifts), 40'(EXT_SEGS));
    countHigh(c);
    chk(c > 0, 1'b1);
    wr(OFF_CTRL, 32'h68);
    waitFrame();
    countHigh(c);
    chk(40'(c), 40'h0);
    standbyIn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(extOeN, 1'b1);
    chk(dividerOn, 1'b0);
    standbyIn <= 1'b0;
    wr(OFF_CTRL, 32'h48);
    repeat (2) @(posedge clk);
    chk(backplane, 4'h0);
    rd(OFF_MODE, 32'h08);
    rd(OFF_CTRL, 32'hc8);
    // Lower half blank, upper half lit: fast frame must show lit
    for (int w = 0; w < 8; w++)
      wr(8'(OFF_RAM + 4 * w), 32'h0);
    wr(OFF_MODE, 32'hf0);
    wr(OFF_CTRL, 32'h70);
    waitFrame();
    chk(segData, {40{1'b1}});
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    tRegs();
    tFrames();
    tDisplay();
    wrapUp();
  end
endmodule
